// file: design/snf_defines.vh
// Constants for the serial NAND command front end
`ifndef SNF_DEFINES_VH
`define SNF_DEFINES_VH
`define SNF_OP_RESET      8'hff
`define SNF_OP_READ_ID    8'h9f
`define SNF_OP_RDSR_A     8'h0f
`define SNF_OP_RDSR_B     8'h05
`define SNF_OP_WRSR_A     8'h1f
`define SNF_OP_WRSR_B     8'h01
`define SNF_OP_WREN       8'h06
`define SNF_OP_WRDI       8'h04
`define SNF_OP_BBM        8'ha1
`define SNF_OP_ERASE      8'hd8
`define SNF_OP_LOAD       8'h02
`define SNF_OP_RLOAD      8'h84
`define SNF_OP_QLOAD      8'h32
`define SNF_OP_RQLOAD     8'h34
`define SNF_OP_EXEC       8'h10
`define SNF_OP_PDREAD     8'h13
`define SNF_OP_QREAD      8'h6b
`define SNF_OP_DREAD      8'h3b
`define SNF_OP_DIOREAD    8'hbb
`define SNF_OP_QIOREAD    8'heb
`define SNF_MAKER_CODE    8'h5a
`define SNF_PART_CODE     16'h1234
`define SNF_BP_NONE       4'h0
`define SNF_BP_MAX_PART   4'h9
`define SNF_BLK_SHIFT     4'h6
`define SNF_PAGE_MAX      16'hffff
`define SNF_BYTE_LAST     3'h7
`define SNF_ADDR_BYTES    3'h3
`define SNF_ID_BYTES      3'h4
`define SNF_ID_FIRST      3'h2
`endif

// file: design/snf_buf2.v
// Two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module snf_buf2 #(
    parameter W = 8
) (
    // Clock and reset
    input  wire         mclk,
    input  wire         resetn,
    // Fill side
    input  wire         in_valid,
    output wire         in_ready,
    input  wire [W-1:0] in_data,
    // Drain side
    output wire         out_valid,
    input  wire         out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_q [0:1];
    reg         wp_q;
    reg         rp_q;
    reg [1:0]   cnt_q;
    wire        push = in_valid && in_ready;
    wire        pop  = out_valid && out_ready;
    assign in_ready  = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data  = mem_q[rp_q];
    always @(posedge mclk)
    begin
        if (push)
            mem_q[wp_q] <= in_data;
    end
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            wp_q  <= 1'b0;
            rp_q  <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
                rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // snf_buf2
`default_nettype wire

// file: design/snf_frontend.v
// Serial NAND command front end with block protection
`timescale 1ns/100ps
`default_nettype none
`include "snf_defines.vh"
module snf_frontend #(
    parameter [7:0]  MAKER = `SNF_MAKER_CODE, // Arbitrary value
    parameter [15:0] PART  = `SNF_PART_CODE   // Arbitrary value
) (
    // Clock and reset
    input  wire        mclk,
    input  wire        resetn,
    // Link pins
    input  wire        cs_n,
    input  wire        sclk,
    input  wire [3:0]  io_in,
    output reg  [3:0]  io_out,
    output reg  [3:0]  io_oe,
    // Status and protection
    input  wire        top_bottom_select,
    input  wire        protect_field_bit3,
    input  wire        protect_field_bit2,
    input  wire        protect_field_bit1,
    input  wire        protect_field_bit0,
    input  wire        busy,
    input  wire        wel,
    output reg         prog_fail_q,
    output reg         erase_fail_q,
    // Accepted command stream
    output reg         cmd_valid_q,
    input  wire        cmd_ready,
    output reg  [7:0]  cmd_op_q,
    output reg  [15:0] cmd_page_q,
    // Incoming byte stream
    output reg         byte_valid_q,
    input  wire        byte_ready,
    output reg  [7:0]  byte_data_q,
    output reg         stall_q
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    reg [5:0] s1_q;
    reg [5:0] s2_q;
    reg       sclk_prev_q;
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_q        <= 6'h01;
            s2_q        <= 6'h01;
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            s1_q        <= {io_in, sclk, cs_n};
            s2_q        <= s1_q;
            sclk_prev_q <= s2_q[1];
        end
    end
    wire       cs_l  = ~s2_q[0];
    wire       rise  = cs_l && s2_q[1] && !sclk_prev_q;
    wire       fall  = cs_l && !s2_q[1] && sclk_prev_q;
    wire [3:0] dsync = s2_q[5:2];
    ////////////////////////////////////////////////////////////////////
    // Protected range decode
    wire [3:0]  bp = {protect_field_bit3, protect_field_bit2,
                      protect_field_bit1, protect_field_bit0};
    reg  [15:0] lo;
    reg  [15:0] hi;
    reg  [15:0] span;
    always @*
    begin
        span = 16'h0;
        lo   = 16'h0;
        hi   = 16'h0;
        if (bp != `SNF_BP_NONE && bp <= `SNF_BP_MAX_PART)
        begin
            span = (16'h1 << (bp + `SNF_BLK_SHIFT)) - 16'h1;
            if (top_bottom_select)
            begin
                lo = 16'h0;
                hi = span;
            end
            else
            begin
                lo = `SNF_PAGE_MAX - span;
                hi = `SNF_PAGE_MAX;
            end
        end
        else if (bp > `SNF_BP_MAX_PART)
            hi = `SNF_PAGE_MAX;
    end
    wire        prot_any = (bp != `SNF_BP_NONE);
    ////////////////////////////////////////////////////////////////////
    // Framing
    reg  [2:0]  bit_q;
    reg  [2:0]  nbyte_q;
    reg  [7:0]  sh_q;
    reg  [7:0]  op_q;
    reg  [15:0] pa_q;
    reg  [23:0] id_q;
    reg         cs_prev_q;
    reg         wide_q;
    reg         quad_q;
    wire        in_op  = (nbyte_q == 3'h0);
    wire [7:0]  sh_n   = quad_q ? {sh_q[3:0], dsync} :
                         wide_q ? {sh_q[5:0], dsync[1:0]} :
                                  {sh_q[6:0], dsync[0]};
    wire [2:0]  step   = quad_q ? 3'h3 : wide_q ? 3'h1 : 3'h0;
    wire        done   = rise && (bit_q + step == `SNF_BYTE_LAST);
    wire        is_rd_id = (op_q == `SNF_OP_READ_ID);
    wire        is_rdsr  = (op_q == `SNF_OP_RDSR_A) || (op_q == `SNF_OP_RDSR_B);
    wire        is_prog  = (op_q == `SNF_OP_EXEC);
    wire        is_erase = (op_q == `SNF_OP_ERASE);
    wire        is_write = is_prog || is_erase || (op_q == `SNF_OP_WRSR_A) ||
                           (op_q == `SNF_OP_WRSR_B) || (op_q == `SNF_OP_WREN) ||
                           (op_q == `SNF_OP_WRDI) || (op_q == `SNF_OP_BBM) ||
                           (op_q == `SNF_OP_LOAD) || (op_q == `SNF_OP_RLOAD) ||
                           (op_q == `SNF_OP_QLOAD) || (op_q == `SNF_OP_RQLOAD) ||
                           (op_q == `SNF_OP_RESET) || (op_q == `SNF_OP_PDREAD);
    wire        busy_ok  = !busy || is_rd_id || is_rdsr;
    wire        hits     = prot_any && (pa_q >= lo) && (pa_q <= hi);
    wire        cs_end   = cs_prev_q && !cs_l;
    wire        whole    = (bit_q == 3'h0) && !in_op;
    wire        out_ready_buf;
    ////////////////////////////////////////////////////////////////////
    // Byte stream buffer
    wire        bvalid;
    wire [7:0]  bdata;
    snf_buf2 #(.W(8)) u_buf (
        .mclk      (mclk),
        .resetn    (resetn),
        .in_valid  (done && !in_op),
        .in_ready  (out_ready_buf),
        .in_data   (sh_n),
        .out_valid (bvalid),
        .out_ready (!byte_valid_q || byte_ready),
        .out_data  (bdata)
    );
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            bit_q        <= 3'h0;
            nbyte_q      <= 3'h0;
            sh_q         <= 8'h0;
            op_q         <= 8'h0;
            pa_q         <= 16'h0;
            id_q         <= 24'h0;
            cs_prev_q    <= 1'b0;
            wide_q       <= 1'b0;
            quad_q       <= 1'b0;
            io_out       <= 4'h0;
            io_oe        <= 4'h0;
            prog_fail_q  <= 1'b0;
            erase_fail_q <= 1'b0;
            cmd_valid_q  <= 1'b0;
            cmd_op_q     <= 8'h0;
            cmd_page_q   <= 16'h0;
            byte_valid_q <= 1'b0;
            byte_data_q  <= 8'h0;
            stall_q      <= 1'b0;
        end
        else
        begin
            cs_prev_q <= cs_l;
            stall_q   <= !out_ready_buf;
            if (!byte_valid_q || byte_ready)
            begin
                byte_valid_q <= bvalid;
                byte_data_q  <= bdata;
            end
            if (cmd_valid_q && cmd_ready)
                cmd_valid_q <= 1'b0;
            if (cs_l && !cs_prev_q)
            begin
                bit_q   <= 3'h0;
                nbyte_q <= 3'h0;
                sh_q    <= 8'h0;
                wide_q  <= 1'b0;
                quad_q  <= 1'b0;
                pa_q    <= 16'h0;
                id_q    <= {MAKER, PART};
            end
            if (rise)
            begin
                sh_q  <= sh_n;
                bit_q <= bit_q + step + 3'h1;
                if (done)
                begin
                    if (in_op)
                    begin
                        op_q   <= sh_n;
                        // Multi-width modes after opcode
                        quad_q <= (sh_n == `SNF_OP_QIOREAD) ||
                                  (sh_n == `SNF_OP_QLOAD) || (sh_n == `SNF_OP_RQLOAD);
                        wide_q <= (sh_n == `SNF_OP_DIOREAD);
                    end
                    else if (nbyte_q <= `SNF_ADDR_BYTES)
                        pa_q <= {pa_q[7:0], sh_n};
                    if (nbyte_q != 3'h7)
                        nbyte_q <= nbyte_q + 3'h1;
                end
            end
            // Drive read data on falling edge; reads stop anywhere
            // Code starts after the dummy byte; the driver sits on lane 1
            if (fall && busy_ok && !in_op && is_rd_id && nbyte_q >= `SNF_ID_FIRST &&
                nbyte_q <= `SNF_ID_BYTES)
            begin
                io_out <= {2'h0, id_q[23], 1'b0};
                io_oe  <= 4'h2;
                id_q   <= {id_q[22:0], 1'b0};
            end
            else if (fall && !(busy_ok && is_rd_id && nbyte_q >= `SNF_ID_FIRST &&
                     nbyte_q <= `SNF_ID_BYTES))
                io_oe  <= 4'h0;
            if (cs_end)
            begin
                io_oe <= 4'h0;
                if (busy_ok && whole && is_write && !busy)
                begin
                    if ((is_prog || is_erase) && hits)
                    begin
                        if (is_prog)
                            prog_fail_q <= 1'b1;
                        else
                            erase_fail_q <= 1'b1;
                    end
                    else
                    begin
                        if (is_prog)
                            prog_fail_q <= 1'b0;
                        if (is_erase)
                            erase_fail_q <= 1'b0;
                        if (op_q == `SNF_OP_RESET)
                        begin
                            prog_fail_q  <= 1'b0;
                            erase_fail_q <= 1'b0;
                        end
                        cmd_valid_q <= 1'b1;
                        cmd_op_q    <= op_q;
                        cmd_page_q  <= pa_q;
                    end
                end
            end
        end
    end
endmodule // snf_frontend
`default_nettype wire

// file: verification/snf_host.sv
// Host link controller model driving chip select, clock and data
`timescale 1ns/100ps
`default_nettype none
module snf_host (
    // Clock
    input  wire logic       mclk,
    // Link pins
    output logic            cs_n,
    output logic            sclk,
    output logic [3:0]      io_in,
    input  wire logic [3:0] io_out
);
    logic [39:0] rx;
    initial
    begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_in = 4'h5;
        rx = 40'h0;
    end
    ////////////////////////////////////////
    // Bits left-aligned in d; clock rests low between frames
    task automatic frame(input logic [39:0] d, input int nbits);
        int k;
        @(posedge mclk) cs_n <= 1'b0;
        for (k = 0; k < nbits; k++)
        begin
            io_in <= {~io_in[3:1], d[39-k]};
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            rx <= {rx[38:0], io_out[1]};
            repeat (4) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        cs_n <= 1'b1;
        io_in <= ~io_in;
        repeat (6) @(posedge mclk);
    endtask
endmodule // snf_host
`default_nettype wire

// file: verification/snf_chk.sv
// Port assertions for the command front end
`timescale 1ns/100ps
`default_nettype none
module snf_chk (
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        cs_n,
    input wire logic        busy,
    input wire logic        cmd_valid_q,
    input wire logic        cmd_ready,
    input wire logic [7:0]  cmd_op_q,
    input wire logic [15:0] cmd_page_q,
    input wire logic        byte_valid_q,
    input wire logic        byte_ready,
    input wire logic [7:0]  byte_data_q,
    input wire logic        stall_q,
    input wire logic        prog_fail_q,
    input wire logic [3:0]  io_oe,
    input wire logic        protect_field_bit3,
    input wire logic        protect_field_bit2,
    input wire logic        protect_field_bit1
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_new_cmd;
        $rose(cmd_valid_q);
    endsequence
    property p_cmd_hold;
        cmd_valid_q && !cmd_ready |=> cmd_valid_q && $stable(cmd_page_q);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("command lost");
    property p_byte_hold;
        byte_valid_q && !byte_ready |=> byte_valid_q && $stable(byte_data_q);
    endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("byte lost");
    property p_cmd_after_cs;
        s_new_cmd |-> $past(cs_n, 2);
    endproperty
    a_cmd_after_cs: assert property (p_cmd_after_cs) else $error("early command");
    property p_all_prot;
        $rose(cmd_valid_q) && protect_field_bit3 && (protect_field_bit2 || protect_field_bit1)
            |-> cmd_op_q != 8'h10 && cmd_op_q != 8'hd8;
    endproperty
    a_all_prot: assert property (p_all_prot) else $error("protected write");
    property p_busy;
        s_new_cmd |-> !$past(busy, 3);
    endproperty
    a_busy: assert property (p_busy) else $error("command while busy");
    property p_not_read;
        s_new_cmd |-> !(cmd_op_q inside {8'h9f, 8'h0f, 8'h05});
    endproperty
    a_not_read: assert property (p_not_read) else $error("read as command");
    property p_fail_after_cs;
        $rose(prog_fail_q) |-> $past(cs_n);
    endproperty
    a_fail_after_cs: assert property (p_fail_after_cs) else $error("early fail");
    property p_stall;
        stall_q |-> byte_valid_q;
    endproperty
    a_stall: assert property (p_stall) else $error("stall with empty buffer");
    property p_oe;
        io_oe != 4'h0 |-> io_oe == 4'h2;
    endproperty
    a_oe: assert property (p_oe) else $error("bad drive enable");
endmodule // snf_chk
bind snf_frontend snf_chk snf_chk_i (.mclk, .resetn, .cs_n, .busy, .cmd_valid_q, .cmd_ready,
    .cmd_op_q, .cmd_page_q, .byte_valid_q, .byte_ready, .byte_data_q, .stall_q, .prog_fail_q,
    .io_oe, .protect_field_bit3, .protect_field_bit2, .protect_field_bit1);
`default_nettype wire

// file: verification/snf_frontend_test.sv
// Self-checking bench for the command front end
`timescale 1ns/100ps
`default_nettype none
`include "snf_defines.vh"
module snf_frontend_test;
    logic        mclk, resetn, busy, cmd_ready, byte_ready, tbs, exp;
    logic [3:0]  bp;
    logic [7:0]  op;
    logic [15:0] pg;
    wire         cs_n, sclk, cmd_valid_q, prog_fail_q, erase_fail_q, byte_valid_q, stall_q;
    wire [3:0]   io_in, io_out, io_oe;
    wire [7:0]   cmd_op_q, byte_data_q;
    wire [15:0]  cmd_page_q;
    int          n_fail, compares, i;
    logic [20:0] cases [10] = '{21'h01ff80, 21'h01ff7f, 21'h11007f, 21'h110080, 21'h098000,
                                21'h197fff, 21'h198000, 21'h1a4000, 21'h0c0000, 21'h00ffff};
    snf_frontend snf_frontend_i (.mclk, .resetn, .cs_n, .sclk, .io_in, .io_out, .io_oe,
        .top_bottom_select(tbs), .protect_field_bit3(bp[3]), .protect_field_bit2(bp[2]),
        .protect_field_bit1(bp[1]), .protect_field_bit0(bp[0]), .busy, .wel(1'b0),
        .prog_fail_q, .erase_fail_q, .cmd_valid_q, .cmd_ready, .cmd_op_q, .cmd_page_q,
        .byte_valid_q, .byte_ready, .byte_data_q, .stall_q);
    snf_host snf_host_i (.mclk, .cs_n, .sclk, .io_in, .io_out);
    ////////////////////////////////////////
    task automatic chk_bit(input logic got, input logic want);
        compares++;
        if (got !== want)
        begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic chk_word(input logic [23:0] got, input logic [23:0] want);
        compares++;
        if (got !== want)
        begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic close_out;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic take_cmd;
        cmd_ready <= 1'b1;
        @(posedge mclk) cmd_ready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic pop;
        byte_ready <= 1'b1;
        @(posedge mclk) byte_ready <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    // Pages per block is 64, so field f of 1 to 9 covers 2^(f+6) pages; 0 covers none, above 9 all
    function automatic logic blocked(input logic t, input logic [3:0] f, input logic [15:0] p);
        logic [16:0] n;
        n = 17'h1 << (f + 4'h6);
        if (f == 4'h0)
            return 1'b0;
        if (f > 4'h9)
            return 1'b1;
        return t ? ({1'b0, p} < n) : ({1'b0, p} >= 17'h10000 - n);
    endfunction
    ////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Whole run is about 4900 cycles
    initial
    begin
        #1000000;
        n_fail++;
        close_out;
    end
    initial
    begin
        {resetn, busy, cmd_ready, tbs, bp} = 8'h0;
        byte_ready = 1'b1;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        snf_host_i.frame({`SNF_OP_READ_ID, 32'h0}, 40);
        chk_word(snf_host_i.rx[23:0], {`SNF_MAKER_CODE, `SNF_PART_CODE});
        for (i = 0; i < 10; i++)
        begin
            {tbs, bp} <= cases[i][20:16];
            pg = cases[i][15:0];
            op = i[0] ? `SNF_OP_ERASE : `SNF_OP_EXEC;
            exp = blocked(cases[i][20], cases[i][19:16], pg);
            snf_host_i.frame({op, 8'h00, pg, 8'h00}, 32);
            chk_bit(cmd_valid_q, !exp);
            chk_bit(i[0] ? erase_fail_q : prog_fail_q, exp);
            if (!exp)
                chk_word({cmd_op_q, cmd_page_q}, {op, pg});
            take_cmd;
        end
        bp <= 4'hc;
        snf_host_i.frame({`SNF_OP_EXEC, 32'h0}, 32);
        chk_bit(prog_fail_q, 1'b1);
        snf_host_i.frame({`SNF_OP_RESET, 32'h0}, 8);
        chk_bit(prog_fail_q, 1'b0);
        take_cmd;
        bp <= 4'h0;
        snf_host_i.frame({`SNF_OP_EXEC, 32'h0}, 31);
        chk_bit(cmd_valid_q, 1'b0);
        busy <= 1'b1;
        snf_host_i.frame({`SNF_OP_EXEC, 32'h0}, 32);
        chk_bit(cmd_valid_q, 1'b0);
        snf_host_i.frame({`SNF_OP_READ_ID, 32'h0}, 40);
        chk_word(snf_host_i.rx[23:0], {`SNF_MAKER_CODE, `SNF_PART_CODE});
        busy <= 1'b0;
        snf_host_i.frame({`SNF_OP_READ_ID, 32'h0}, 13);
        snf_host_i.frame({`SNF_OP_EXEC, 32'h0}, 32);
        chk_bit(cmd_valid_q, 1'b1);
        take_cmd;
        byte_ready <= 1'b0;
        snf_host_i.frame({`SNF_OP_LOAD, 32'ha1b2c300}, 32);
        chk_bit(stall_q, 1'b1);
        chk_word({16'h0, byte_data_q}, 24'ha1);
        take_cmd;
        pop;
        chk_word({16'h0, byte_data_q}, 24'hb2);
        pop;
        chk_word({16'h0, byte_data_q}, 24'hc3);
        pop;
        chk_bit(byte_valid_q, 1'b0);
        close_out;
    end
endmodule // snf_frontend_test
`default_nettype wire
